/* File: design/plce_defs.svh */
`ifndef PLCE_DEFS_SVH
`define PLCE_DEFS_SVH

// Data FIFO shape
`define PLCE_FIFO_WIDTH 1
`define PLCE_FIFO_DEPTH 32

// Symbol delay line length, longest substitution
`define PLCE_WIN 8

// Zero-run lengths that trigger a substitution
`define PLCE_RUN_HDB3 4'h4
`define PLCE_RUN_B3ZS 4'h3
`define PLCE_RUN_B6ZS 4'h6
`define PLCE_RUN_B8ZS 4'h8
`define PLCE_RUN_NONE 4'h0

// Half-bit pair for a zero in two-level mode
`define PLCE_CMI_ZERO 2'h1

// Symbols the decoder swallows before its output is valid
`define PLCE_FILL 4'h8

`endif

/* File: design/plce_pkg.sv */
`include "plce_defs.svh"

package plce_pkg;

  // Line code selection
  typedef enum logic [2:0] {
    MODE_AMI,
    MODE_HDB3,
    MODE_B3ZS,
    MODE_B6ZS,
    MODE_B8ZS,
    MODE_CMI
  } plce_mode_t;

  // Kind of symbol held in the encoder delay line
  typedef enum logic [2:0] {
    SYM_ZERO,
    SYM_ONE,
    SYM_SZ,
    SYM_B,
    SYM_V
  } plce_kind_t;

  // Zero-run length that a mode replaces, zero for none
  function automatic logic [3:0] plce_run_len(plce_mode_t m);
    case (m)
      MODE_HDB3: return `PLCE_RUN_HDB3;
      MODE_B3ZS: return `PLCE_RUN_B3ZS;
      MODE_B6ZS: return `PLCE_RUN_B6ZS;
      MODE_B8ZS: return `PLCE_RUN_B8ZS;
      default:   return `PLCE_RUN_NONE;
    endcase
  endfunction : plce_run_len

endpackage : plce_pkg

/* File: design/plce_sym_if.sv */
`timescale 1ns/1ps

// Received line symbols: ternary pair, half-bit pair and a strobe
interface plce_sym_if;
  logic       pos;
  logic       neg;
  logic [1:0] cmi;
  logic       valid;
  modport src (output pos, output neg, output cmi, output valid);
  modport snk (input pos, input neg, input cmi, input valid);
endinterface : plce_sym_if

/* File: design/plce_fifo.sv */
`timescale 1ns/1ps

module plce_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic [AW:0]      occ_d;
  logic             ov_d;
  logic             wr;
  logic             rd;

  // Read refills the output register when it is empty or taken
  assign wr    = in_valid_i && in_ready_o;
  assign rd    = (cnt_q != '0) && (!out_valid_o || out_ready_i);
  assign cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  assign ov_d  = rd || (out_valid_o && !out_ready_i);
  assign occ_d = cnt_d + (AW+1)'(ov_d); // Output register counts toward depth

  // Storage
  always_ff @(posedge clock_i) begin
    if (wr) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers, fill count and registered ready
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wp_q       <= wp_q + AW'(wr);
      rp_q       <= rp_q + AW'(rd);
      cnt_q      <= cnt_d;
      in_ready_o <= (occ_d != (AW+1)'(DEPTH));
    end
  end

  // Output register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
    end else if (rd) begin
      out_data_o  <= mem_q[rp_q];
      out_valid_o <= 1'b1;
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  a_fifo_no_over: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cnt_q + (AW+1)'(out_valid_o) == (AW+1)'(DEPTH) |-> !in_ready_o)
    else $error("fifo accepts data while full");

endmodule : plce_fifo

/* File: design/plce_decoder.sv */
`timescale 1ns/1ps
`include "plce_defs.svh"

module plce_decoder
  import plce_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire plce_mode_t mode_i,
  plce_sym_if.snk         sym,
  output logic            bit_o,
  output logic            bit_valid_o,
  output logic            viol_o
);

  logic [`PLCE_WIN-1:0] p_q;
  logic [`PLCE_WIN-1:0] v_q;
  logic [`PLCE_WIN-1:0] p_d;
  logic [`PLCE_WIN-1:0] v_d;
  logic [`PLCE_WIN-1:0] pc;
  logic [`PLCE_WIN-1:0] clr;
  logic                 lpol_q;
  logic                 seen_q;
  logic                 clvl_q;
  logic [3:0]           fill_q;
  logic                 one;
  logic                 newp;
  logic                 newv;

  // Classify the arriving symbol as a pulse and maybe a violation
  always_comb begin
    one = (sym.cmi == 2'h0) || (sym.cmi == 2'h3);
    if (mode_i == MODE_CMI) begin
      newp = one || (sym.cmi == 2'h2);
      newv = (sym.cmi == 2'h2) || (one && seen_q && sym.cmi[1] == clvl_q);
    end else begin
      newp = sym.pos || sym.neg;
      newv = newp && seen_q && (sym.pos == lpol_q);
    end
  end

  // Shift in, then wipe a recognised substitution back to zeros
  always_comb begin
    p_d = {p_q[`PLCE_WIN-2:0], newp};
    v_d = {v_q[`PLCE_WIN-2:0], newv};
    pc  = p_d & ~v_d;
    clr = '0;
    case (mode_i)
      MODE_HDB3: if (v_d[0] && !p_d[1] && !p_d[2] && !v_d[3]) clr = 8'h0F; // R12
      MODE_B3ZS: if (v_d[0] && !p_d[1] && !v_d[2]) clr = 8'h07; // R12
      MODE_B6ZS: if (pc[0] && v_d[1] && !p_d[2] && pc[3] && v_d[4] && !p_d[5]) begin
        clr = 8'h3F; // R12
      end
      MODE_B8ZS: if (pc[0] && v_d[1] && !p_d[2] && pc[3] && v_d[4]
                     && p_d[7:5] == 3'h0) begin
        clr = 8'hFF; // R12
      end
      default: clr = '0;
    endcase
    p_d = p_d & ~clr;
    v_d = v_d & ~clr;
  end

  // Delay line and polarity tracking
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p_q    <= '0;
      v_q    <= '0;
      lpol_q <= 1'b0;
      seen_q <= 1'b0;
      clvl_q <= 1'b0;
    end else if (sym.valid) begin
      p_q <= p_d;
      v_q <= v_d;
      if (sym.pos || sym.neg) begin
        lpol_q <= sym.pos;
      end
      if (newp) begin
        seen_q <= 1'b1;
      end
      if (one) begin
        clvl_q <= sym.cmi[1];
      end
    end
  end

  // Decoded bit leaves the oldest slot; leftover violations are flagged
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_o       <= 1'b0;
      bit_valid_o <= 1'b0;
      viol_o      <= 1'b0;
      fill_q      <= '0;
    end else begin
      bit_valid_o <= sym.valid && (fill_q == `PLCE_FILL);
      if (sym.valid) begin
        bit_o  <= p_q[`PLCE_WIN-1];
        viol_o <= v_q[`PLCE_WIN-1] && (fill_q == `PLCE_FILL); // R12
        if (fill_q != `PLCE_FILL) begin
          fill_q <= fill_q + 4'h1;
        end
      end
    end
  end

  a_dec_viol_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R12
    $rose(viol_o) |-> bit_o && $past(sym.valid))
    else $error("violation flagged on a zero bit");

endmodule : plce_decoder

/* File: design/plce_encoder.sv */
`timescale 1ns/1ps
`include "plce_defs.svh"

// How it works
// [R01] AMI: ones become pulses of alternating polarity, zeros become no pulse.
// [R02] Inserted B follows alternation; inserted V repeats the previous pulse polarity.
// [R03] HDB3: each run of four zeros becomes 000V or B00V.
// [R04] HDB3: pick pattern so an odd count of B/marks separates violations.
// [R05] B3ZS: each run of three zeros becomes 00V or B0V.
// [R06] B3ZS: pick pattern so an odd count of B/marks separates violations.
// [R07] B6ZS: each run of six zeros becomes 0VB0VB.
// [R08] B8ZS: each run of eight zeros becomes 000VB0VB.
// [R09] CMI: a one holds one level all bit, alternating between successive ones.
// [R10] CMI: a zero is low then high, rising at mid-bit.
// [R11] CMI uses two levels; the AMI family uses positive, negative and zero.
// [R12] Mode input selects among six codes; decoder undoes substitutions, flags stray violations.
// [R13] CMI output is a half-bit pair per bit clock.
module plce_encoder
  import plce_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire plce_mode_t mode_i,
  input  wire logic       tx_bit_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic       line_ready_i,
  output logic            line_pos_o,
  output logic            line_neg_o,
  output logic [1:0]      line_cmi_o,
  output logic            line_valid_o,
  input  wire logic       rx_pos_i,
  input  wire logic       rx_neg_i,
  input  wire logic [1:0] rx_cmi_i,
  input  wire logic       rx_valid_i,
  output logic            rx_bit_o,
  output logic            rx_bit_valid_o,
  output logic            rx_viol_o
);

  logic [`PLCE_FIFO_WIDTH-1:0] f_data;
  logic                        f_valid;
  logic                        adv;
  plce_kind_t                  in_k;
  plce_kind_t                  emit_k;
  plce_kind_t                  slot_q [`PLCE_WIN];
  plce_kind_t                  slot_d [`PLCE_WIN];
  logic [3:0]                  run_n;
  logic [2:0]                  oi;
  logic                        odd;
  logic                        sub;
  logic                        last_pol_q;
  logic                        par_q;
  logic                        lvl_q;
  logic                        lvl_d;
  logic                        pulse;
  logic                        pol;

  plce_sym_if rx_sym ();

  // Substitution symbol at pattern position p, p zero sent first
  function automatic plce_kind_t sub_pat(plce_mode_t m, logic [2:0] p, logic odd_i);
    plce_kind_t k;
    k = SYM_SZ;
    case (m)
      MODE_HDB3: begin
        if (p == 3'h3) k = SYM_V; // R03
        else if (p == 3'h0 && !odd_i) k = SYM_B; // R04
      end
      MODE_B3ZS: begin
        if (p == 3'h2) k = SYM_V; // R05
        else if (p == 3'h0 && !odd_i) k = SYM_B; // R06
      end
      MODE_B6ZS: begin
        if (p == 3'h1 || p == 3'h4) k = SYM_V; // R07
        else if (p == 3'h2 || p == 3'h5) k = SYM_B; // R07
      end
      MODE_B8ZS: begin
        if (p == 3'h3 || p == 3'h6) k = SYM_V; // R08
        else if (p == 3'h4 || p == 3'h7) k = SYM_B; // R08
      end
      default: k = SYM_SZ;
    endcase
    return k;
  endfunction : sub_pat

  // Bit buffer between framer and line; line back-pressure fills it
  plce_fifo #(
    .WIDTH(`PLCE_FIFO_WIDTH),
    .DEPTH(`PLCE_FIFO_DEPTH)
  ) u_fifo (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .in_data_i  (tx_bit_i),
    .in_valid_i (tx_valid_i),
    .in_ready_o (tx_ready_o),
    .out_data_o (f_data),
    .out_valid_o(f_valid),
    .out_ready_i(line_ready_i)
  );

  // One symbol per clock while the line takes it; underrun sends zeros
  assign adv   = line_ready_i;
  assign in_k  = (f_valid && f_data[0]) ? SYM_ONE : SYM_ZERO;
  assign run_n = plce_run_len(mode_i); // R12
  assign oi    = (run_n == 4'h0) ? 3'h0 : 3'(run_n - 4'h1);

  // The symbol leaving the window now, and the mark parity it completes; a V restarts it
  assign emit_k = slot_q[oi];
  assign odd    = (emit_k == SYM_V) ? 1'b0 // R04 R06
                : par_q ^ (emit_k == SYM_ONE || emit_k == SYM_B);

  // Next window: shift, and replace a full run of data zeros
  always_comb begin
    slot_d[0] = in_k;
    for (int i = 1; i < `PLCE_WIN; i++) begin
      slot_d[i] = slot_q[i-1];
    end
    sub = (run_n != 4'h0);
    for (int i = 0; i < `PLCE_WIN; i++) begin
      if (4'(i) < run_n && slot_d[i] != SYM_ZERO) begin
        sub = 1'b0;
      end
    end
    for (int i = 0; i < `PLCE_WIN; i++) begin
      if (sub && 4'(i) < run_n) begin
        slot_d[i] = sub_pat(mode_i, 3'(run_n - 4'(i) - 4'h1), odd); // R03 R05 R07 R08
      end
    end
  end

  // Symbol delay line; reset fill is filler zeros that never start a run
  for (genvar g = 0; g < `PLCE_WIN; g++) begin : g_slot
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        slot_q[g] <= SYM_SZ;
      end else if (adv) begin
        slot_q[g] <= slot_d[g];
      end
    end
  end

  // Polarity of the emitted pulse: marks and B flip, V repeats
  always_comb begin
    pulse = (emit_k == SYM_ONE) || (emit_k == SYM_B) || (emit_k == SYM_V); // R01
    pol   = (emit_k == SYM_V) ? last_pol_q : !last_pol_q; // R02
    lvl_d = !lvl_q;
  end

  // Last pulse polarity and mark parity since the last violation
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_pol_q <= 1'b0;
      par_q      <= 1'b0;
    end else if (adv) begin
      case (emit_k)
        SYM_ONE, SYM_B: begin
          last_pol_q <= !last_pol_q; // R01 R02
          par_q      <= !par_q; // R04 R06
        end
        SYM_V: par_q <= 1'b0; // R04 R06
        default: par_q <= par_q;
      endcase
    end
  end

  // Ternary line outputs, quiet in two-level mode
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_pos_o <= 1'b0;
      line_neg_o <= 1'b0;
    end else if (adv) begin
      line_pos_o <= (mode_i != MODE_CMI) && pulse && pol; // R11
      line_neg_o <= (mode_i != MODE_CMI) && pulse && !pol; // R11
    end
  end

  // Two-level half-bit pair, first half in bit 1
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cmi_o <= 2'h0;
      lvl_q      <= 1'b0;
    end else if (adv) begin
      if (mode_i != MODE_CMI) begin
        line_cmi_o <= 2'h0; // R11
      end else if (emit_k == SYM_ONE) begin
        line_cmi_o <= {lvl_d, lvl_d}; // R09 R13
        lvl_q      <= lvl_d; // R09
      end else begin
        line_cmi_o <= `PLCE_CMI_ZERO; // R10 R13
      end
    end
  end

  // Symbol strobe toward the line
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_valid_o <= 1'b0;
    end else begin
      line_valid_o <= adv;
    end
  end

  // Receive path carried to the decoder
  assign rx_sym.pos   = rx_pos_i;
  assign rx_sym.neg   = rx_neg_i;
  assign rx_sym.cmi   = rx_cmi_i;
  assign rx_sym.valid = rx_valid_i;

  plce_decoder u_dec (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .mode_i     (mode_i),
    .sym        (rx_sym.snk),
    .bit_o      (rx_bit_o),
    .bit_valid_o(rx_bit_valid_o),
    .viol_o     (rx_viol_o)
  );

  // Checking helpers: data zero run, last pulse and last violation polarity
  logic [3:0] zrun_q;
  logic       ppol_q;
  logic       pseen_q;
  logic       vpol_q;
  logic       vseen_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zrun_q  <= 4'h0;
      ppol_q  <= 1'b0;
      pseen_q <= 1'b0;
      vpol_q  <= 1'b0;
      vseen_q <= 1'b0;
    end else begin
      if (adv) begin
        if (emit_k != SYM_ZERO) zrun_q <= 4'h0;
        else if (zrun_q != 4'hF) zrun_q <= zrun_q + 4'h1;
        if (emit_k == SYM_V) begin
          vpol_q  <= last_pol_q;
          vseen_q <= 1'b1;
        end
      end
      if (line_valid_o && (line_pos_o || line_neg_o)) begin
        ppol_q  <= line_pos_o;
        pseen_q <= 1'b1;
      end
    end
  end

  a_three_level: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R11
    !(line_pos_o && line_neg_o))
    else $error("both ternary rails active");

  a_cmi_two_level: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R11
    line_valid_o && mode_i == MODE_CMI && $past(mode_i) == MODE_CMI
      |-> !line_pos_o && !line_neg_o)
    else $error("ternary rail active in two-level mode");

  a_cmi_zero_mid: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R10
    adv && mode_i == MODE_CMI && emit_k == SYM_ZERO |=> line_cmi_o == 2'h1)
    else $error("zero not sent low then high");

  a_cmi_one_alt: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R09
    adv && mode_i == MODE_CMI && emit_k == SYM_ONE
      |=> line_cmi_o[1] == line_cmi_o[0] && line_cmi_o[1] != $past(lvl_q))
    else $error("one level not alternating");

  a_ami_alternate: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R01
    mode_i == MODE_AMI && pseen_q && line_valid_o && (line_pos_o || line_neg_o)
      |-> line_pos_o != ppol_q)
    else $error("marks do not alternate");

  a_viol_same_pol: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R02
    adv && emit_k == SYM_V && mode_i != MODE_CMI
      |=> line_pos_o == $past(last_pol_q) && (line_pos_o || line_neg_o))
    else $error("violation polarity not repeated");

  a_viol_alternate: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R04 R06
    adv && emit_k == SYM_V && vseen_q && (mode_i == MODE_HDB3 || mode_i == MODE_B3ZS)
      |-> last_pol_q != vpol_q)
    else $error("successive violations share polarity");

  a_zero_run_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R03 R05 R07 R08
    run_n != 4'h0 |-> zrun_q < run_n)
    else $error("unsubstituted zero run too long");

endmodule : plce_encoder

/* File: dv/plce_line_model.sv */
`timescale 1ns/1ps

// Line side stand-in: paces the line and loops each symbol back to the receiver
module plce_line_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       stall_i,
  input  wire logic       slow_i,
  input  wire logic       inj_i,
  input  wire logic       line_pos_i,
  input  wire logic       line_neg_i,
  input  wire logic [1:0] line_cmi_i,
  input  wire logic       line_valid_i,
  output logic            line_ready_o,
  output logic            rx_pos_o,
  output logic            rx_neg_o,
  output logic [1:0]      rx_cmi_o,
  output logic            rx_valid_o
);
  logic inj_done_q;

  // Ready pacing: held off, every cycle, or every other cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) line_ready_o <= 1'b0;
    else if (stall_i) line_ready_o <= 1'b0;
    else if (slow_i) line_ready_o <= ~line_ready_o;
    else line_ready_o <= 1'b1;
  end

  // Echo one cycle later; idle cycles show a toggling pattern, not the last symbol
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_pos_o   <= 1'b0;
      rx_neg_o   <= 1'b0;
      rx_cmi_o   <= 2'h0;
      rx_valid_o <= 1'b0;
      inj_done_q <= 1'b0;
    end else if (line_valid_i) begin
      rx_valid_o <= 1'b1;
      rx_cmi_o   <= line_cmi_i;
      if (inj_i && !inj_done_q && (line_pos_i || line_neg_i)) begin
        rx_pos_o   <= line_neg_i; // Flip one pulse to fake a stray violation
        rx_neg_o   <= line_pos_i;
        inj_done_q <= 1'b1;
      end else begin
        rx_pos_o <= line_pos_i;
        rx_neg_o <= line_neg_i;
      end
    end else begin
      rx_valid_o <= 1'b0;
      rx_pos_o   <= ~rx_pos_o;
      rx_neg_o   <= ~rx_neg_o;
      rx_cmi_o   <= ~rx_cmi_o;
    end
  end
endmodule : plce_line_model

/* File: dv/test_pdh_line_code_encoder.sv */
`timescale 1ns/1ps

module test_pdh_line_code_encoder;
  import plce_pkg::*;

  localparam logic [31:0] PATTERN = 32'hB0080261;
  localparam int          NSYM    = 40;

  logic       clock_i, rst_n_i, tx_bit_i, tx_valid_i, tx_ready_o, line_ready_i;
  logic       line_pos_o, line_neg_o, line_valid_o, rx_pos_i, rx_neg_i, rx_valid_i;
  logic       rx_bit_o, rx_bit_valid_o, rx_viol_o, line_stall, line_slow, line_inj;
  logic       rdy_q, viol_seen;
  logic [1:0] line_cmi_o, rx_cmi_i;
  logic [1:0] exp_sym [NSYM];
  logic [1:0] sym_q [$];
  logic       dec_q [$];
  plce_mode_t mode_i;
  int         n_fail, check_count;

  plce_encoder i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .tx_bit_i(tx_bit_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .line_ready_i(line_ready_i), .line_pos_o(line_pos_o), .line_neg_o(line_neg_o),
    .line_cmi_o(line_cmi_o), .line_valid_o(line_valid_o), .rx_pos_i(rx_pos_i),
    .rx_neg_i(rx_neg_i), .rx_cmi_i(rx_cmi_i), .rx_valid_i(rx_valid_i),
    .rx_bit_o(rx_bit_o), .rx_bit_valid_o(rx_bit_valid_o), .rx_viol_o(rx_viol_o));

  plce_line_model i_line (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(line_stall),
    .slow_i(line_slow), .inj_i(line_inj), .line_pos_i(line_pos_o), .line_neg_i(line_neg_o),
    .line_cmi_i(line_cmi_o), .line_valid_i(line_valid_o), .line_ready_o(line_ready_i),
    .rx_pos_o(rx_pos_i), .rx_neg_o(rx_neg_i), .rx_cmi_o(rx_cmi_i), .rx_valid_o(rx_valid_i));

  // Bit clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  function automatic logic pbit(input int i);
    return (i < 32) ? PATTERN[31-i] : 1'b0;
  endfunction : pbit

  // Collect line symbols and decoded bits; level usage is judged per symbol
  always @(posedge clock_i) begin
    if (rst_n_i) begin
      check("line valid follows ready", 32'(rdy_q), 32'(line_valid_o));
      if (line_valid_o === 1'b1) begin
        if (mode_i == MODE_CMI) begin
          sym_q.push_back(line_cmi_o);
          check("ternary lines in two-level mode", 0, 32'({line_pos_o, line_neg_o}));
        end else begin
          sym_q.push_back({line_pos_o, line_neg_o});
          check("unused levels", 0, 32'({line_pos_o & line_neg_o, line_cmi_o}));
        end
      end
      if (rx_bit_valid_o === 1'b1) begin
        dec_q.push_back(rx_bit_o);
        viol_seen = viol_seen | rx_viol_o;
      end
    end
    rdy_q = rst_n_i & line_ready_i;
  end

  // Reference coder over the pattern followed by zeros
  task automatic ref_enc(input plce_mode_t m);
    int    i, k, n, cnt;
    logic  pol, lvl, zr;
    string sub;
    n = (m == MODE_HDB3) ? 4 : (m == MODE_B3ZS) ? 3 : (m == MODE_B6ZS) ? 6 :
        (m == MODE_B8ZS) ? 8 : 0;
    pol = 1'b0;
    lvl = 1'b0;
    cnt = 0;
    i = 0;
    while (i < NSYM) begin
      zr = (n != 0);
      for (k = 0; k < n; k++) zr = zr & ~pbit(i + k);
      if (m == MODE_CMI) begin
        lvl = pbit(i) ? ~lvl : lvl;
        exp_sym[i] = pbit(i) ? {lvl, lvl} : 2'h1;
        i++;
      end else if (pbit(i)) begin
        pol = ~pol;
        exp_sym[i] = pol ? 2'h2 : 2'h1;
        cnt++;
        i++;
      end else if (zr) begin
        case (m)
          MODE_HDB3: sub = (cnt % 2 == 0) ? "B00V" : "000V";
          MODE_B3ZS: sub = (cnt % 2 == 0) ? "B0V" : "00V";
          MODE_B6ZS: sub = "0VB0VB";
          default:   sub = "000VB0VB";
        endcase
        for (k = 0; k < n; k++) begin
          if (sub[k] == "B") pol = ~pol;
          if (sub[k] == "B") cnt++;
          if (sub[k] == "V") cnt = 0;
          if (i + k < NSYM) exp_sym[i+k] = (sub[k] == "0") ? 2'h0 : (pol ? 2'h2 : 2'h1);
        end
        i += n;
      end else begin
        exp_sym[i] = 2'h0;
        i++;
      end
    end
  endtask : ref_enc

  task automatic do_reset(input plce_mode_t m);
    rst_n_i    <= 1'b0;
    line_stall <= 1'b1;
    line_inj   <= 1'b0;
    mode_i     <= m;
    repeat (3) @(posedge clock_i);
    check("ready in reset", 1, 32'(tx_ready_o));
    check("outputs in reset", 0, 32'({line_valid_o, rx_bit_valid_o, rx_viol_o}));
    rst_n_i <= 1'b1;
    @(posedge clock_i);
  endtask : do_reset

  // Fill the buffer past full with the line held, then drain and loop back
  task automatic run_mode(input plce_mode_t m, input logic s, input logic j);
    int acc, first, w;
    do_reset(m);
    line_slow  <= s;
    acc = 0;
    tx_valid_i <= 1'b1;
    tx_bit_i   <= pbit(0);
    for (w = 0; w < 45; w++) begin
      @(posedge clock_i);
      if (tx_ready_o === 1'b1) acc++;
      tx_bit_i <= pbit(acc);
    end
    tx_valid_i <= 1'b0;
    check("bits accepted", 32, 32'(acc));
    check("ready while full", 0, 32'(tx_ready_o));
    sym_q.delete();
    dec_q.delete();
    viol_seen = 1'b0;
    line_inj   <= j;
    line_stall <= 1'b0;
    for (w = 0; w < 1000 && (sym_q.size() < 60 || dec_q.size() < 50); w++) @(posedge clock_i);
    check("drain finished", 1, 32'(w < 1000));
    if (w < 1000) begin
      ref_enc(m);
      for (first = 0; first < 20; first++)
        if (sym_q[first] == ((m == MODE_CMI) ? 2'h3 : 2'h2)) break;
      for (w = 0; w < NSYM; w++)
        check("line symbol", 32'(exp_sym[w]), 32'(sym_q[first+w]));
      for (first = 0; first < 18; first++)
        if (dec_q[first] === 1'b1) break;
      for (w = 0; w < 32 && !j; w++)
        check("decoded bit", 32'(pbit(w)), 32'(dec_q[first+w]));
      check("violation flag", 32'(j), 32'(viol_seen));
    end
    $display("test %s slow %0d inject %0d done", m.name(), s, j);
  endtask : run_mode

  initial begin
    rst_n_i      = 1'b0;
    mode_i       = MODE_AMI;
    tx_bit_i     = 1'b0;
    tx_valid_i   = 1'b0;
    line_stall   = 1'b1;
    line_slow    = 1'b0;
    line_inj     = 1'b0;
    rdy_q        = 1'b0;
    viol_seen    = 1'b0;
    n_fail       = 0;
    check_count  = 0;
    run_mode(MODE_AMI, 1'b0, 1'b0);
    run_mode(MODE_HDB3, 1'b1, 1'b0);
    run_mode(MODE_B3ZS, 1'b0, 1'b0);
    run_mode(MODE_B6ZS, 1'b1, 1'b0);
    run_mode(MODE_B8ZS, 1'b0, 1'b0);
    run_mode(MODE_CMI, 1'b1, 1'b0);
    run_mode(MODE_AMI, 1'b1, 1'b1);
    test_done();
  end

  // Watchdog sized well beyond seven drains of a few hundred cycles each
  initial begin
    #200000;
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end
endmodule : test_pdh_line_code_encoder
